// File: hw/bldr_top.sv
// Boot sequencer: NVM to unified RAM load, status variables, boot flags
// Functional notes
// [R1] User part with autorun: load, enable debug port, run from 0 at once.
// [R2] Run part: load as user part, then run from 0 with debug disabled.
// [R3] Factory part, or user part without autorun, waits in loop.
// [R4] Run part may be reopened for retest unless retest is locked.
// [R5] Debug host can still halt an autorunning user part.
// [R6] Result byte 0x00 or 0x80 means success, else boot error.
// [R7] Boot fail bit in flags register mirrors the result byte.
// [R8] One RAM 0x0000..0x11FF serves fetch, data moves and code reads.
// [R9] User code and data are copied from NVM into RAM bottom.
// [R10] Status variables are written to 0x11F3..0x11FF at boot end.
// [R11] Multi-byte variables are big-endian, high byte at lower address.
// [R12] Word at 0x11F3 gives first RAM address of factory data.
// [R13] Word at 0x11F5 gives NVM user load start, used after factory load.
// [R14] Word at 0x11FD holds first NVM address not read.
// [R15] Result byte is 8 bits at 0x11FF.
// [R16] Result bit 7 holds GPIO0 sampled before crystal oscillator start.
// [R17] Software must not write RAM from the reserved start upward.
// [R18] Factory data area is rewritten on every boot.
// [R19] Program level register reports the current program level.
// [R20] Wait loop holds until either run-code bit is set.
// [R21] Force-factory bit skips user load, waits; cleared on power-on. Code honours it for user-level parts only; run parts ignore it.
// [R22] Result bits 4:2 factory error, bit 1 later block, bit 0 first.
// [R23] All status variables are written before wait or jump.
`timescale 1ns/1ps
`include "bldr_regs.svh"
module bldr_top #(
  parameter int RAM_DEPTH = `BLDR_RAM_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic boot_restart_i,
  input wire logic gpio0_i,
  input wire logic dbg_halt_i,
  input wire logic retest_req_i,
  output logic [12:0] nvm_addr_o,
  output logic nvm_rd_o,
  input wire logic [7:0] nvm_data_i,
  input wire logic nvm_ack_i,
  input wire logic nvm_err_i,
  input wire logic [12:0] cpu_ram_addr_i,
  input wire logic cpu_ram_we_i,
  input wire logic [7:0] cpu_ram_wdata_i,
  output logic [7:0] cpu_ram_rdata_o,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic xo_en_o,
  output logic dbg_port_en_o,
  output logic cpu_run_o,
  output logic cpu_halt_o,
  output logic [12:0] cpu_start_addr_o
);

  bldr_pkg::bldr_state_t state, next_state;
  logic [2:0] hdr_idx, next_hdr_idx;
  logic [3:0] stat_idx, next_stat_idx;
  logic [12:0] nvm_ptr, next_nvm_ptr;
  logic [12:0] dst, next_dst;
  logic [15:0] cnt, next_cnt;
  logic [7:0] hdr_hi, next_hdr_hi;
  logic [2:0] level, next_level;
  logic [7:0] prot, next_prot;
  logic [15:0] trim, next_trim;
  logic [15:0] user_start, next_user_start;
  logic [2:0] ferr, next_ferr;
  logic uerr_first, next_uerr_first;
  logic uerr_next, next_uerr_next;
  logic first_blk, next_first_blk;
  logic gpio_bit, next_gpio_bit;
  logic xo_en, next_xo_en;
  logic dbg_en, next_dbg_en;
  logic run, next_run;
  logic boot_end;
  logic [7:0] flags, next_flags;
  logic [7:0] rdata, next_rdata;
  logic [2:0] sync1, sync2;
  logic gpio_s, halt_s, retest_s;
  logic [15:0] hdr_word;
  logic [7:0] result;
  logic skip_user;
  logic run_bits;
  logic [7:0] stat_byte;
  logic stat_we;

  bldr_ram_if ram_bus ();

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // No reset, so the pin level is settled when reset releases
  always_ff @(posedge core_clk_i) begin
    sync1 <= {retest_req_i, dbg_halt_i, gpio0_i};
    sync2 <= sync1;
  end

  assign gpio_s = sync2[0];
  assign halt_s = sync2[1];
  assign retest_s = sync2[2];

  // ---------------------------------------------------------------
  // Derived terms
  // ---------------------------------------------------------------
  assign hdr_word = {hdr_hi, nvm_data_i};
  // [R15] [R16] [R22] result byte layout
  assign result = {gpio_bit, 2'b00, ferr, uerr_next, uerr_first};
  // [R21] force bit beats autorun
  assign skip_user = (ferr != `BLDR_FERR_NONE) ||
    (level == bldr_pkg::LVL_FACTORY) ||
    ((level == bldr_pkg::LVL_USER) && flags[`BLDR_FL_FORCE]) ||
    ((level != bldr_pkg::LVL_USER) && (level != bldr_pkg::LVL_RUN));
  // [R20] either run-code bit
  assign run_bits = flags[`BLDR_FL_RUN_SYS] || flags[`BLDR_FL_RUN_POR];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_hdr_idx = hdr_idx;
    next_stat_idx = stat_idx;
    next_nvm_ptr = nvm_ptr;
    next_dst = dst;
    next_cnt = cnt;
    next_hdr_hi = hdr_hi;
    next_level = level;
    next_prot = prot;
    next_trim = trim;
    next_user_start = user_start;
    next_ferr = ferr;
    next_uerr_first = uerr_first;
    next_uerr_next = uerr_next;
    next_first_blk = first_blk;
    next_gpio_bit = gpio_bit;
    next_xo_en = xo_en;
    next_dbg_en = dbg_en;
    next_run = run;
    boot_end = 1'b0;
    unique case (state)
      bldr_pkg::ST_SAMPLE: begin
        // [R16] pin taken before oscillator enable
        next_gpio_bit = gpio_s;
        next_nvm_ptr = 13'h0000;
        next_hdr_idx = 3'd0;
        next_ferr = `BLDR_FERR_NONE;
        next_uerr_first = 1'b0;
        next_uerr_next = 1'b0;
        next_first_blk = 1'b1;
        next_state = bldr_pkg::ST_FHDR;
      end
      bldr_pkg::ST_FHDR: begin
        if (nvm_ack_i) begin
          next_nvm_ptr = nvm_ptr + 13'd1;
          next_hdr_idx = hdr_idx + 3'd1;
          next_hdr_hi = nvm_data_i;
          if (nvm_err_i) begin
            next_ferr = `BLDR_FERR_READ;
            next_state = bldr_pkg::ST_STAT;
          end else begin
            unique case (hdr_idx)
              3'd0: next_level = nvm_data_i[2:0];
              3'd1: begin
                next_prot = nvm_data_i;
                next_xo_en = nvm_data_i[`BLDR_PB_XO];
              end
              3'd3: next_trim = hdr_word;
              3'd5: next_user_start = hdr_word;
              3'd7: begin
                next_cnt = hdr_word;
                next_dst = trim[12:0];
                if (trim > `BLDR_TRIM_LIMIT) begin
                  next_ferr = `BLDR_FERR_RANGE;
                  next_state = bldr_pkg::ST_STAT;
                end else if (hdr_word != 16'h0000) begin
                  next_state = bldr_pkg::ST_FCOPY;
                end else if (skip_user) begin
                  next_state = bldr_pkg::ST_STAT;
                end else begin
                  next_nvm_ptr = user_start[12:0];
                  next_hdr_idx = 3'd0;
                  next_state = bldr_pkg::ST_UHDR;
                end
              end
              default: ;
            endcase
          end
        end
      end
      // [R18] factory image copied on every boot
      bldr_pkg::ST_FCOPY: begin
        if (nvm_ack_i) begin
          next_nvm_ptr = nvm_ptr + 13'd1;
          next_dst = dst + 13'd1;
          next_cnt = cnt - 16'd1;
          if (nvm_err_i) begin
            next_ferr = `BLDR_FERR_READ;
            next_state = bldr_pkg::ST_STAT;
          end else if (cnt == 16'd1) begin
            if (skip_user) begin
              next_state = bldr_pkg::ST_STAT;
            end else begin
              // [R13] user load start from factory header
              next_nvm_ptr = user_start[12:0];
              next_hdr_idx = 3'd0;
              next_state = bldr_pkg::ST_UHDR;
            end
          end
        end
      end
      bldr_pkg::ST_UHDR: begin
        if (nvm_ack_i) begin
          next_nvm_ptr = nvm_ptr + 13'd1;
          next_hdr_idx = hdr_idx + 3'd1;
          next_hdr_hi = nvm_data_i;
          if (nvm_err_i) begin
            next_uerr_first = first_blk;
            next_uerr_next = !first_blk;
            next_state = bldr_pkg::ST_STAT;
          end else if (hdr_idx == 3'd1) begin
            next_dst = hdr_word[12:0];
          end else if (hdr_idx == `BLDR_UHDR_LAST) begin
            next_cnt = hdr_word;
            if (hdr_word == 16'h0000) begin
              next_state = bldr_pkg::ST_STAT;
            end else begin
              next_state = bldr_pkg::ST_UCOPY;
            end
          end
        end
      end
      // [R9] user blocks into RAM
      bldr_pkg::ST_UCOPY: begin
        if (nvm_ack_i) begin
          next_nvm_ptr = nvm_ptr + 13'd1;
          next_dst = dst + 13'd1;
          next_cnt = cnt - 16'd1;
          if (nvm_err_i) begin
            // [R22] first or later block error
            next_uerr_first = first_blk;
            next_uerr_next = !first_blk;
            next_state = bldr_pkg::ST_STAT;
          end else if (cnt == 16'd1) begin
            next_first_blk = 1'b0;
            next_hdr_idx = 3'd0;
            next_state = bldr_pkg::ST_UHDR;
          end
        end
      end
      // [R23] exit only after last status byte
      bldr_pkg::ST_STAT: begin
        next_stat_idx = stat_idx + 4'd1;
        if (stat_idx == `BLDR_STAT_LAST) begin
          next_stat_idx = 4'd0;
          boot_end = 1'b1;
          if (level == bldr_pkg::LVL_RUN && ferr == `BLDR_FERR_NONE) begin
            // [R4] retest entry unless locked
            if (retest_s && !prot[`BLDR_PB_RETEST_LOCK]) begin
              next_dbg_en = 1'b1;
              next_state = bldr_pkg::ST_WAIT;
            end else begin
              // [R2] run with debug off
              next_dbg_en = 1'b0;
              next_run = 1'b1;
              next_state = bldr_pkg::ST_RUN;
            end
          end else if (level == bldr_pkg::LVL_USER && !skip_user &&
                       prot[`BLDR_PB_AUTORUN]) begin
            // [R1] autorun with debug on
            next_dbg_en = 1'b1;
            next_run = 1'b1;
            next_state = bldr_pkg::ST_RUN;
          end else begin
            // [R3] [R21] wait loop with debug on
            next_dbg_en = 1'b1;
            next_state = bldr_pkg::ST_WAIT;
          end
        end
      end
      // [R20] hold until host releases
      bldr_pkg::ST_WAIT: begin
        if (run_bits) begin
          next_run = 1'b1;
          next_state = bldr_pkg::ST_RUN;
        end
      end
      bldr_pkg::ST_RUN: ;
      default: next_state = bldr_pkg::ST_SAMPLE;
    endcase
    if (boot_restart_i) begin
      next_state = bldr_pkg::ST_SAMPLE;
      next_run = 1'b0;
      next_dbg_en = 1'b0;
      next_xo_en = 1'b0;
      next_stat_idx = 4'd0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= bldr_pkg::ST_SAMPLE;
      hdr_idx <= 3'd0;
      stat_idx <= 4'd0;
      nvm_ptr <= 13'h0000;
      dst <= 13'h0000;
      cnt <= 16'h0000;
      hdr_hi <= 8'h00;
      level <= 3'h0;
      prot <= 8'h00;
      trim <= 16'h0000;
      user_start <= 16'h0000;
      ferr <= 3'h0;
      uerr_first <= 1'b0;
      uerr_next <= 1'b0;
      first_blk <= 1'b1;
      gpio_bit <= 1'b0;
      xo_en <= 1'b0;
      dbg_en <= 1'b0;
      run <= 1'b0;
    end else begin
      state <= next_state;
      hdr_idx <= next_hdr_idx;
      stat_idx <= next_stat_idx;
      nvm_ptr <= next_nvm_ptr;
      dst <= next_dst;
      cnt <= next_cnt;
      hdr_hi <= next_hdr_hi;
      level <= next_level;
      prot <= next_prot;
      trim <= next_trim;
      user_start <= next_user_start;
      ferr <= next_ferr;
      uerr_first <= next_uerr_first;
      uerr_next <= next_uerr_next;
      first_blk <= next_first_blk;
      gpio_bit <= next_gpio_bit;
      xo_en <= next_xo_en;
      dbg_en <= next_dbg_en;
      run <= next_run;
    end
  end

  // ---------------------------------------------------------------
  // Status variable bytes
  // ---------------------------------------------------------------
  // [R10] [R11] [R12] [R14] big-endian status words
  always_comb begin
    unique case (stat_idx)
      4'd0: stat_byte = trim[15:8];
      4'd1: stat_byte = trim[7:0];
      4'd2: stat_byte = user_start[15:8];
      4'd3: stat_byte = user_start[7:0];
      4'd10: stat_byte = {3'b000, nvm_ptr[12:8]};
      4'd11: stat_byte = nvm_ptr[7:0];
      4'd12: stat_byte = result;
      default: stat_byte = 8'h00;
    endcase
  end

  assign stat_we = (state == bldr_pkg::ST_STAT) &&
    ((stat_idx < `BLDR_STAT_GAP_LO) || (stat_idx > `BLDR_STAT_GAP_HI));

  // ---------------------------------------------------------------
  // RAM and NVM connections
  // ---------------------------------------------------------------
  // [R8] one RAM for fetch and data
  assign ram_bus.cpu_addr = cpu_ram_addr_i;
  assign ram_bus.cpu_we = cpu_ram_we_i;
  assign ram_bus.cpu_wdata = cpu_ram_wdata_i;
  assign cpu_ram_rdata_o = ram_bus.cpu_rdata;
  assign ram_bus.ld_we = stat_we || (nvm_ack_i && !nvm_err_i &&
    (state == bldr_pkg::ST_FCOPY || state == bldr_pkg::ST_UCOPY));
  assign ram_bus.ld_addr = (state == bldr_pkg::ST_STAT) ?
    `BLDR_STAT_BASE + {9'd0, stat_idx} : dst;
  assign ram_bus.ld_wdata = (state == bldr_pkg::ST_STAT) ?
    stat_byte : nvm_data_i;

  bldr_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ram(ram_bus)
  );

  assign nvm_addr_o = nvm_ptr;
  assign nvm_rd_o = (state == bldr_pkg::ST_FHDR) ||
    (state == bldr_pkg::ST_FCOPY) || (state == bldr_pkg::ST_UHDR) ||
    (state == bldr_pkg::ST_UCOPY);

  // ---------------------------------------------------------------
  // Boot flags register
  // ---------------------------------------------------------------
  always_comb begin
    next_flags = flags;
    if (sfr_wr_i && sfr_addr_i == `BLDR_SFR_FLAGS) begin
      next_flags = sfr_wdata_i;
    end
    if (boot_restart_i) begin
      next_flags[`BLDR_FL_RUN_SYS] = 1'b0;
      next_flags[`BLDR_FL_DONE] = 1'b0;
      next_flags[`BLDR_FL_FAIL] = 1'b0;
    end
    // [R6] [R7] hardware set wins over write
    if (boot_end) begin
      next_flags[`BLDR_FL_DONE] = 1'b1;
      next_flags[`BLDR_FL_FAIL] = (result[6:0] != 7'h00);
    end
  end

  // [R21] force bit kept over restart, cleared by power-on or a flags write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= `BLDR_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        `BLDR_SFR_FLAGS: next_rdata = flags;
        // [R19] program level readout
        `BLDR_SFR_LEVEL: next_rdata = {5'b00000, level};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sfr_rdata_o = rdata;
  assign xo_en_o = xo_en;
  assign dbg_port_en_o = dbg_en;
  assign cpu_run_o = run;
  // [R5] host halt while debug port open
  assign cpu_halt_o = dbg_en && halt_s;
  assign cpu_start_addr_o = `BLDR_JUMP_ADDR;

endmodule : bldr_top

// File: hw/bldr_regs.svh
// Boot loader constants: addresses, field positions, reset values
`ifndef BLDR_REGS_SVH
`define BLDR_REGS_SVH

// ---------------------------------------------------------------
// Memory geometry
// ---------------------------------------------------------------
`define BLDR_RAM_DEPTH 4608
`define BLDR_RAM_AW 13
`define BLDR_NVM_AW 13
`define BLDR_JUMP_ADDR 13'h0000

// ---------------------------------------------------------------
// Boot status variables in unified RAM
// ---------------------------------------------------------------
`define BLDR_STAT_BASE 13'h11f3
`define BLDR_RESERVED_START_ADDR 13'h11f3
`define BLDR_USER_START_ADDR 13'h11f5
`define BLDR_NEXT_UNREAD_ADDR 13'h11fd
`define BLDR_RESULT_ADDR 13'h11ff
`define BLDR_TRIM_LIMIT 16'h11f3
`define BLDR_STAT_LAST 4'd12
`define BLDR_STAT_GAP_LO 4'd4
`define BLDR_STAT_GAP_HI 4'd9

// ---------------------------------------------------------------
// Result byte fields
// ---------------------------------------------------------------
`define BLDR_RES_GPIO 7
`define BLDR_RES_FERR_HI 4
`define BLDR_RES_FERR_LO 2
`define BLDR_RES_UERR_NEXT 1
`define BLDR_RES_UERR_FIRST 0
`define BLDR_FERR_NONE 3'h0
`define BLDR_FERR_READ 3'h1
`define BLDR_FERR_RANGE 3'h2

// ---------------------------------------------------------------
// Special function registers
// ---------------------------------------------------------------
`define BLDR_SFR_FLAGS 8'hdd
`define BLDR_SFR_LEVEL 8'hde
`define BLDR_FLAGS_RESET 8'h00
`define BLDR_FL_FORCE 5
`define BLDR_FL_RUN_POR 4
`define BLDR_FL_FAIL 2
`define BLDR_FL_DONE 1
`define BLDR_FL_RUN_SYS 0

// ---------------------------------------------------------------
// Factory and user header layout and boot protection byte bits
// ---------------------------------------------------------------
`define BLDR_FHDR_LAST 3'd7
`define BLDR_UHDR_LAST 3'd3
`define BLDR_PB_AUTORUN 0
`define BLDR_PB_RETEST_LOCK 1
`define BLDR_PB_XO 2

`endif

// File: hw/bldr_pkg.sv
// Boot loader types
package bldr_pkg;

  typedef enum logic [3:0] {
    ST_SAMPLE = 4'b0000,
    ST_FHDR = 4'b0001,
    ST_FCOPY = 4'b0011,
    ST_UHDR = 4'b0010,
    ST_UCOPY = 4'b0110,
    ST_STAT = 4'b0111,
    ST_WAIT = 4'b0101,
    ST_RUN = 4'b0100
  } bldr_state_t;

  typedef enum logic [2:0] {
    LVL_FACTORY = 3'h0,
    LVL_USER = 3'h1,
    LVL_RUN = 3'h3
  } bldr_level_t;

endpackage : bldr_pkg

// File: hw/bldr_ram_if.sv
// Ports of the unified code and data RAM
`timescale 1ns/1ps
interface bldr_ram_if;
  logic [12:0] cpu_addr;
  logic cpu_we;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic ld_we;
  logic [12:0] ld_addr;
  logic [7:0] ld_wdata;

  modport ctrl (
    output cpu_addr, cpu_we, cpu_wdata, ld_we, ld_addr, ld_wdata,
    input cpu_rdata
  );
  modport mem (
    input cpu_addr, cpu_we, cpu_wdata, ld_we, ld_addr, ld_wdata,
    output cpu_rdata
  );
endinterface : bldr_ram_if

// File: hw/bldr_ram.sv
// Unified code and external data RAM with a loader write port
`timescale 1ns/1ps
`include "bldr_regs.svh"
module bldr_ram #(
  parameter int DEPTH = `BLDR_RAM_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  bldr_ram_if.mem ram
);

  logic [7:0] mem [DEPTH];
  logic [7:0] next_rdata;
  logic [7:0] rdata;
  logic cpu_in;
  logic ld_in;

  assign cpu_in = 32'(ram.cpu_addr) < DEPTH;
  assign ld_in = 32'(ram.ld_addr) < DEPTH;
  assign ram.cpu_rdata = rdata;

  // ---------------------------------------------------------------
  // Storage, loader port wins a same-address collision
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (ram.cpu_we && cpu_in) begin
      mem[ram.cpu_addr] <= ram.cpu_wdata;
    end
    if (ram.ld_we && ld_in) begin
      mem[ram.ld_addr] <= ram.ld_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Registered read for fetch and data moves
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (cpu_in) begin
      next_rdata = mem[ram.cpu_addr];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : bldr_ram

// File: dv/bldr_nvm_model.sv
// NVM read port model with random stalls and one faulty address
`timescale 1ns/1ps
module bldr_nvm_model (
  input wire logic core_clk_i,
  input wire logic rd_i,
  input wire logic [12:0] addr_i,
  output logic ack_o,
  output logic err_o,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:8191];
  logic [12:0] err_addr = 13'h1fff;
  initial ack_o = 1'b0;
  initial err_o = 1'b0;
  initial data_o = 8'h00;
  // One byte per ack, idle data scrambled
  always @(posedge core_clk_i) begin
    if (rd_i && !ack_o && $urandom_range(2, 0) != 0) begin
      ack_o <= 1'b1;
      data_o <= mem[addr_i];
      err_o <= addr_i == err_addr;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule : bldr_nvm_model

// File: dv/bldr_top_checker.sv
// Port-level assertions for the boot loader
`timescale 1ns/1ps
module bldr_top_checker #(
  parameter int RAM_DEPTH = 4608
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic nvm_rd_o,
  input wire logic nvm_ack_i,
  input wire logic [12:0] nvm_addr_o,
  input wire logic [12:0] cpu_ram_addr_i,
  input wire logic [7:0] cpu_ram_rdata_o,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic dbg_port_en_o,
  input wire logic cpu_run_o,
  input wire logic cpu_halt_o,
  input wire logic [12:0] cpu_start_addr_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_stall;
    nvm_rd_o && !nvm_ack_i;
  endsequence
  sequence s_go;
    sfr_wr_i && sfr_addr_i == 8'hdd && (sfr_wdata_i[0] || sfr_wdata_i[4]);
  endsequence
  a_start_zero: assert property (
    cpu_start_addr_o == 13'h0000) else $error("start addr");
  a_halt_gated: assert property (
    cpu_halt_o |-> dbg_port_en_o) else $error("halt ungated");
  a_nvm_stall: assert property (
    s_stall |=> $stable(nvm_addr_o)) else $error("addr moved");
  a_load_first: assert property (
    cpu_run_o |-> !nvm_rd_o) else $error("run during load");
  a_wait_exit: assert property (
    s_go ##0 dbg_port_en_o |-> ##[1:2] cpu_run_o) else $error("no run");
  a_sfr_blank: assert property (
    sfr_rd_i && !(sfr_addr_i inside {8'hdd, 8'hde}) |=>
    sfr_rdata_o == 8'h00) else $error("sfr not zero");
  a_sfr_hold: assert property (
    !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("rdata moved");
  a_ram_oob: assert property (
    cpu_ram_addr_i >= RAM_DEPTH |=> cpu_ram_rdata_o == 8'h00)
    else $error("oob read");
endmodule : bldr_top_checker
bind bldr_top bldr_top_checker #(.RAM_DEPTH(RAM_DEPTH)) chk_u (.*);

// File: dv/tb_top.sv
// Self-checking bench for the boot loader top
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 0, rst_n_i = 0, boot_restart_i = 0, gpio0_i = 0;
  logic dbg_halt_i = 0, retest_req_i = 0, cpu_ram_we_i = 0;
  logic sfr_wr_i = 0, sfr_rd_i = 0, nvm_rd_o, nvm_ack_i, nvm_err_i;
  logic [12:0] nvm_addr_o, cpu_ram_addr_i = 0, cpu_start_addr_o;
  logic [7:0] nvm_data_i, cpu_ram_wdata_i = 0, cpu_ram_rdata_o;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
  logic xo_en_o, dbg_port_en_o, cpu_run_o, cpu_halt_o;
  int failures = 0, compares = 0;
  // Nibbles: dbg, run, retest, mode, protection, level
  localparam logic [23:0] CFG [10] = '{24'h110011, 24'h100111,
    24'h010003, 24'h100010, 24'h100001, 24'h101003, 24'h011063,
    24'h100201, 24'h100301, 24'h110011};
  always #50 core_clk_i = ~core_clk_i;
  bldr_top dut_u (.*);
  bldr_nvm_model nvm_u (.core_clk_i(core_clk_i), .rd_i(nvm_rd_o),
    .addr_i(nvm_addr_o), .ack_o(nvm_ack_i), .err_o(nvm_err_i),
    .data_o(nvm_data_i));
  task automatic final_report();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic sfr(input logic [7:0] a, input logic [7:0] d,
      input logic w, output logic [7:0] q);
    @(negedge core_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = w;
    sfr_rd_i = !w;
    @(negedge core_clk_i);
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    q = sfr_rdata_o;
  endtask : sfr
  task automatic ram(input logic [12:0] a, input logic [7:0] d,
      input logic w, output logic [7:0] q);
    @(negedge core_clk_i);
    cpu_ram_addr_i = a;
    cpu_ram_wdata_i = d;
    cpu_ram_we_i = w;
    @(negedge core_clk_i);
    cpu_ram_we_i = 1'b0;
    q = cpu_ram_rdata_o;
  endtask : ram
  task automatic wchk(input logic [12:0] a, input logic [15:0] e);
    logic [7:0] h, l;
    ram(a, 8'h00, 1'b0, h);
    ram(a + 13'h0001, 8'h00, 1'b0, l);
    chk({h, l}, e);
  endtask : wchk
  function automatic logic [7:0] exp_res(logic g, logic [1:0] md);
    return {g, 2'b00, (md == 2'd3) ? 3'h2 : 3'h0, 1'b0, md == 2'd2};
  endfunction : exp_res
  function automatic logic [15:0] exp_next(logic [2:0] lv,
      logic [1:0] md, logic [15:0] us, logic [7:0] ul);
    if (md == 2'd2) return us + 16'h0005;
    if ((lv == 3'd1 && md == 2'd0) || lv == 3'd3) return us + 8 + ul;
    return us;
  endfunction : exp_next
  task automatic boot(input logic [23:0] c);
    logic [2:0] lv;
    logic [1:0] md;
    logic [15:0] rs, us, dst;
    logic [7:0] fl, ul, q, r;
    int i;
    lv = c[2:0];
    md = c[9:8];
    fl = $urandom_range(8, 1);
    ul = $urandom_range(6, 1);
    dst = $urandom_range(255, 0);
    rs = (md == 2'd3) ? 16'h11f4 : 16'h11f3 - fl;
    us = 16'h0008 + fl;
    gpio0_i = $urandom;
    retest_req_i = c[12];
    for (i = 0; i < 32; i++) nvm_u.mem[i] = $urandom;
    {nvm_u.mem[0], nvm_u.mem[1]} = {5'h00, lv, 5'h00, c[6:4]};
    {nvm_u.mem[2], nvm_u.mem[3], nvm_u.mem[4], nvm_u.mem[5]} = {rs, us};
    {nvm_u.mem[6], nvm_u.mem[7]} = {8'h00, fl};
    {nvm_u.mem[us], nvm_u.mem[us + 1]} = dst;
    {nvm_u.mem[us + 2], nvm_u.mem[us + 3]} = {8'h00, ul};
    for (i = 0; i < 4; i++) nvm_u.mem[us + 4 + ul + i] = 8'h00;
    nvm_u.err_addr = (md == 2'd2) ? 13'(us + 4) : 13'h1fff;
    if (md == 2'd1) begin
      sfr(8'hdd, 8'h20, 1'b1, q);
      boot_restart_i = 1'b1;
      @(negedge core_clk_i);
      boot_restart_i = 1'b0;
    end else begin
      rst_n_i = 1'b0;
      repeat (12) @(negedge core_clk_i);
      rst_n_i = 1'b1;
    end
    r = 8'h00;
    for (i = 0; i < 300 && r[1] !== 1'b1; i++) sfr(8'hdd, 0, 0, r);
    q = exp_res(gpio0_i, md);
    chk(r[2:1], {|q[6:0], 1'b1});
    repeat (2) @(negedge core_clk_i);
    chk({dbg_port_en_o, cpu_run_o, xo_en_o}, {c[20], c[16], c[6]});
    chk(cpu_start_addr_o, 16'h0000);
    ram(13'h11ff, 8'h00, 1'b0, r);
    chk(r, q);
    if (md != 2'd3) begin
      wchk(13'h11f3, rs);
      wchk(13'h11f5, us);
      wchk(13'h11fd, exp_next(lv, md, us, ul));
      ram(rs[12:0], 8'h00, 1'b0, r);
      chk(r, nvm_u.mem[8]);
      ram(dst[12:0], 8'h00, 1'b0, r);
      if (exp_next(lv, md, us, ul) > us + 5) chk(r, nvm_u.mem[us + 4]);
    end
    sfr(8'hde, 8'h00, 1'b0, r);
    chk(r, {5'h00, lv});
    if (c[16] == 1'b0) begin
      chk(cpu_run_o, 1'b0);
      sfr(8'hdd, (lv == 3'd0) ? 8'h10 : 8'h01, 1'b1, r);
      repeat (2) @(negedge core_clk_i);
      chk(cpu_run_o, 1'b1);
    end
  endtask : boot
  initial begin
    logic [7:0] q, r;
    void'($urandom(32'hd8f9));
    for (int k = 0; k < 10; k++) begin
      boot(CFG[k]);
      dbg_halt_i = $urandom;
      repeat (3) @(negedge core_clk_i);
      chk(cpu_halt_o, dbg_halt_i & CFG[k][20]);
      dbg_halt_i = 1'b0;
    end
    for (int n = 0; n < 20; n++) begin
      q = $urandom;
      ram(13'($urandom_range(4095, 0)), q, 1'b1, r);
      ram(cpu_ram_addr_i, 8'h00, 1'b0, r);
      chk(r, q);
    end
    ram(13'h1200, 8'h00, 1'b0, r);
    chk(r, 8'h00);
    sfr(8'h55, 8'h00, 1'b0, r);
    chk(r, 8'h00);
    final_report();
  end
  initial begin
    #5000000;
    failures++;
    final_report();
  end
endmodule : tb_top
